//--- tmrdv_pkg.sv
/*
  Shared constants for the dual 8-bit timer / event counter / divider block:
  register byte addresses, control field positions, reset values, mode and
  clock-select codes, and prescaler exponents.
  Assumes a single 250 MHz system clock that acts as the fast clock fc.
*/
package tmrdv_pkg;

  localparam int CLK_MHZ = 250;
  localparam int CNT_W = 8;

  // Register byte addresses on the AHB-Lite slave
  localparam logic [7:0] ADDR_CTRL0 = 8'h00;
  localparam logic [7:0] ADDR_CTRL1 = 8'h04;
  localparam logic [7:0] ADDR_CMP0 = 8'h08;
  localparam logic [7:0] ADDR_CMP1 = 8'h0C;
  localparam logic [7:0] ADDR_SYS = 8'h10;
  localparam logic [7:0] ADDR_STAT = 8'h14;

  // timer_control_reg layout
  localparam int CTL_MODE_LSB = 0;
  localparam int CTL_RUN_BIT = 3;
  localparam int CTL_CSEL_LSB = 4;
  localparam int CTL_FF_BIT = 7;

  // System register layout
  localparam int SYS_SLOW_BIT = 0;
  localparam int SYS_PWR_LSB = 1;

  // Status register layout
  localparam int STAT_CNT1_LSB = 8;
  localparam int STAT_FF_LSB = 16;

  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CMP_RST = 8'hFF;
  localparam logic SLOW_SEL_RST = 1'b0;

  // mode_select_field codes
  typedef enum logic [2:0] {
    MODE_TIMER = 3'b000,
    MODE_DIVIDER = 3'b001,
    MODE_PWM = 3'b010,
    MODE_RSVD = 3'b011,
    MODE_CASCADE = 3'b100
  } tmrdv_mode_type;

  // Clock select codes
  localparam logic [2:0] CSEL_SLOW = 3'b000;
  localparam logic [2:0] CSEL_PIN = 3'b111;

  typedef enum logic [1:0] {
    PWR_FULL = 2'b00,
    PWR_HALT = 2'b01,
    PWR_LOW = 2'b10,
    PWR_LOW_HALT = 2'b11
  } tmrdv_power_type;

  // Prescaler exponents (fc/2^n, fs/2^n)
  localparam int PRE_FC3 = 3;
  localparam int PRE_FC5 = 5;
  localparam int PRE_FC7 = 7;
  localparam int PRE_FC11 = 11;
  localparam int PRE_FS3 = 3;
  localparam int FS_W = 16;
  // Approx. 32.768 kHz from 250 MHz
  localparam int FS_DIV_DEFAULT = 7629;

endpackage

//--- tmrdv_prescale.sv
/*
  Prescaler: turns the system clock into one-cycle enables for the internal
  timer sources fc/2^3, fc/2^5, fc/2^7, fc/2^11 and fs/2^3.
  Assumes fs is emulated by dividing the system clock by FS_DIV.
*/
`timescale 1ns/1ns
module tmrdv_prescale import tmrdv_pkg::*; #(
  parameter int FS_DIV = FS_DIV_DEFAULT
) (
  input wire logic clk, // System clock
  input wire logic rst, // Async reset, high
  output logic tick_fc3, // fc/2^3 enable
  output logic tick_fc5, // fc/2^5 enable
  output logic tick_fc7, // fc/2^7 enable
  output logic tick_fc11, // fc/2^11 enable
  output logic tick_fs3 // fs/2^3 enable
);

  typedef struct packed {
    logic [PRE_FC11-1:0] fc_cnt;
    logic [FS_W-1:0] fs_cnt;
    logic [PRE_FS3-1:0] fs3_cnt;
  } tmrdv_pre_state_type;

  tmrdv_pre_state_type st;
  tmrdv_pre_state_type next_st;
  logic fs_tick;

  assign fs_tick = st.fs_cnt == FS_W'(FS_DIV - 1);
  assign tick_fc3 = &st.fc_cnt[PRE_FC3-1:0];
  assign tick_fc5 = &st.fc_cnt[PRE_FC5-1:0];
  assign tick_fc7 = &st.fc_cnt[PRE_FC7-1:0];
  assign tick_fc11 = &st.fc_cnt;
  assign tick_fs3 = fs_tick & (&st.fs3_cnt);

  always_comb begin
    next_st = st;
    next_st.fc_cnt = st.fc_cnt + PRE_FC11'(1);
    next_st.fs_cnt = fs_tick ? '0 : st.fs_cnt + FS_W'(1);
    if (fs_tick) begin
      next_st.fs3_cnt = st.fs3_cnt + PRE_FS3'(1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule // tmrdv_prescale

//--- tmrdv_stage.sv
/*
  One up-counter stage. Counts by inc on each adv enable, clears on clr,
  and is held at zero while run is low. Two stages chain into 16 bits by
  feeding the lower carry into the upper inc.
  Assumes the parent decides when a compare match has happened.
*/
`timescale 1ns/1ns
module tmrdv_stage import tmrdv_pkg::*; #(
  parameter int W = CNT_W
) (
  input wire logic clk, // System clock
  input wire logic rst, // Async reset, high
  input wire logic run, // Low stops and clears
  input wire logic adv, // Count enable
  input wire logic inc, // Amount added on adv
  input wire logic clr, // Match clear, with adv
  input wire logic [W-1:0] cmp, // Compare value
  output logic [W-1:0] count, // Present count
  output logic eq_next, // Count plus inc equals cmp
  output logic carry // Count at all ones
);

  typedef struct packed {
    logic [W-1:0] count;
  } tmrdv_stage_state_type;

  tmrdv_stage_state_type st;
  tmrdv_stage_state_type next_st;

  assign count = st.count;
  assign carry = &st.count;
  assign eq_next = W'(st.count + W'(inc)) == cmp;

  always_comb begin
    next_st = st;
    if (!run) begin
      next_st.count = '0;
    end else if (adv) begin
      next_st.count = clr ? '0 : W'(st.count + W'(inc));
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule // tmrdv_stage

//--- tmrdv_top.sv
/*
  Dual 8-bit timer / event counter / programmable divider with an AHB-Lite
  register slave. Stage 1 can cascade onto stage 0 as a 16-bit counter.
  Assumes a single-master AHB-Lite bus, synchronous inputs and a 250 MHz CLK.
  PWM, warm-up and pulse generator modes do not count here.
*/
`timescale 1ns/1ns
// Summary of operation
// - Timer mode: count, match interrupt, clear, restart
// - Event mode: count falling pin edges, match clears
// - Compare register unbuffered, writes act at once
// - Divider: match toggles flip-flop, clears, interrupts
// - Divider pin is inverse of flip-flop
// - Software loads flip-flop; reset clears it
// - Stop holds pin; change flip-flop afterwards
// - Cascade uses lower stage clock select
// - Low power: only divided slow clock
// - Full speed: fc/2^7,5,3, slow source selectable
// - Run bit low stops and clears count
// - Mode field codes timer, divider, cascade
module tmrdv_top import tmrdv_pkg::*; #(
  parameter int FS_DIV = FS_DIV_DEFAULT
) (
  input wire logic CLK, // System clock, 250 MHz
  input wire logic RST, // Async reset, high
  input wire logic HSEL, // Slave select
  input wire logic [31:0] HADDR, // Byte address
  input wire logic [1:0] HTRANS, // Transfer type
  input wire logic HWRITE, // Write when high
  input wire logic [2:0] HSIZE, // Word only
  input wire logic [31:0] HWDATA, // Write data
  input wire logic HREADY, // Bus ready
  output logic [31:0] HRDATA, // Read data
  output logic HREADYOUT, // Always ready
  output logic HRESP, // Always OKAY
  input wire logic [1:0] EVENT_IN, // event_input_pin per stage
  output logic [1:0] DIV_OUT_N, // divider_output_pin, inverted
  output logic [1:0] MATCH_IRQ // match_interrupt pulses
);

  typedef struct packed {
    logic [1:0][7:0] ctrl;
    logic [1:0][7:0] cmp;
    logic slow_sel;
    logic [1:0] pwr;
    logic [1:0] ff;
    logic [1:0] pin_n;
    logic [1:0] irq;
    logic [1:0] ev_s1;
    logic [1:0] ev_s2;
    logic [1:0] ev_prev;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
    logic ready;
    logic resp;
  } tmrdv_top_state_type;

  tmrdv_top_state_type st;
  tmrdv_top_state_type next_st;

  logic tick_fc3;
  logic tick_fc5;
  logic tick_fc7;
  logic tick_fc11;
  logic tick_fs3;
  logic [1:0] fall;
  logic low_power;
  logic cascade;
  logic [1:0][2:0] mode;
  logic [1:0][2:0] csel;
  logic [1:0] run_bit;
  logic [1:0][3:0] int_vec;
  logic [1:0] int_tick;
  logic [1:0] src_tick;
  logic [1:0] counts;
  logic run0;
  logic run1;
  logic adv1;
  logic inc1;
  logic match0;
  logic match1;
  logic match_cas;
  logic [7:0] cnt0;
  logic [7:0] cnt1;
  logic eq0;
  logic eq1;
  logic carry0;
  logic addr_ok;

  tmrdv_prescale #(.FS_DIV(FS_DIV)) u_pre (
    .clk(CLK),
    .rst(RST),
    .tick_fc3(tick_fc3),
    .tick_fc5(tick_fc5),
    .tick_fc7(tick_fc7),
    .tick_fc11(tick_fc11),
    .tick_fs3(tick_fs3)
  );

  assign fall = st.ev_prev & ~st.ev_s2;
  assign low_power = st.pwr[1];
  assign cascade = mode[1] == MODE_CASCADE;

  // Source clock per stage; invalid selections simply never tick
  for (genvar j = 0; j < 2; j++) begin : g_src
    assign mode[j] = st.ctrl[j][CTL_MODE_LSB+:3];
    assign csel[j] = st.ctrl[j][CTL_CSEL_LSB+:3];
    assign run_bit[j] = st.ctrl[j][CTL_RUN_BIT];
    assign int_vec[j] = {tick_fc3, tick_fc5, tick_fc7, st.slow_sel ? tick_fs3 : tick_fc11};
    assign int_tick[j] = csel[j][2] ? 1'b0 :
      low_power ? (csel[j] == CSEL_SLOW) & tick_fs3 : int_vec[j][csel[j][1:0]];
    // Pin edges feed only timer/event mode and the lower stage in cascade, never the divider
    assign src_tick[j] = (csel[j] == CSEL_PIN) ? fall[j] & (mode[j] == MODE_TIMER | (j == 0 & cascade))
      : int_tick[j];
    assign counts[j] = mode[j] == MODE_TIMER | mode[j] == MODE_DIVIDER;
  end

  // In cascade the upper run bit starts both stages
  assign run0 = cascade ? run_bit[1] : run_bit[0] & counts[0];
  assign run1 = run_bit[1] & (counts[1] | cascade);
  assign adv1 = cascade ? src_tick[0] : src_tick[1];
  assign inc1 = cascade ? carry0 : 1'b1;
  assign match0 = !cascade & run0 & src_tick[0] & eq0;
  assign match_cas = cascade & run1 & src_tick[0] & eq0 & eq1;
  assign match1 = (!cascade & run1 & src_tick[1] & eq1) | match_cas;

  tmrdv_stage #(.W(CNT_W)) u_stage0 (
    .clk(CLK),
    .rst(RST),
    .run(run0),
    .adv(src_tick[0]),
    .inc(1'b1),
    .clr(match0 | match_cas),
    .cmp(st.cmp[0]),
    .count(cnt0),
    .eq_next(eq0),
    .carry(carry0)
  );

  tmrdv_stage #(.W(CNT_W)) u_stage1 (
    .clk(CLK),
    .rst(RST),
    .run(run1),
    .adv(adv1),
    .inc(inc1),
    .clr(match1),
    .cmp(st.cmp[1]),
    .count(cnt1),
    .eq_next(eq1),
    .carry()
  );

  assign addr_ok = HSEL & HREADY & HTRANS[1];

  always_comb begin
    next_st = st;
    next_st.ev_s1 = EVENT_IN;
    next_st.ev_s2 = st.ev_s1;
    next_st.ev_prev = st.ev_s2;
    next_st.irq = {match1, match0};
    // Divider output toggles on each match
    if (match0 && mode[0] == MODE_DIVIDER) begin
      next_st.ff[0] = !st.ff[0];
    end
    if (match1 && mode[1] == MODE_DIVIDER) begin
      next_st.ff[1] = !st.ff[1];
    end
    // Data phase of a write
    if (st.wr_pend) begin
      case (st.wr_addr)
        ADDR_CTRL0, ADDR_CTRL1: begin
          // A stopping write leaves the flip-flop, so the pin holds
          if (!run_bit[st.wr_addr[2]]) begin
            next_st.ff[st.wr_addr[2]] = HWDATA[CTL_FF_BIT];
          end
          next_st.ctrl[st.wr_addr[2]] = HWDATA[7:0];
        end
        ADDR_CMP0: next_st.cmp[0] = HWDATA[7:0];
        ADDR_CMP1: next_st.cmp[1] = HWDATA[7:0];
        ADDR_SYS: begin
          next_st.slow_sel = HWDATA[SYS_SLOW_BIT];
          next_st.pwr = HWDATA[SYS_PWR_LSB+:2];
        end
        default: begin
        end
      endcase
    end
    next_st.pin_n = ~next_st.ff;
    next_st.wr_pend = addr_ok & HWRITE;
    next_st.wr_addr = HADDR[7:0];
    // Register reads taken from post-write values so back-to-back reads are fresh; the status word uses the present st.ff
    if (addr_ok && !HWRITE) begin
      case (HADDR[7:0])
        ADDR_CTRL0: next_st.rdata = {24'h000000, next_st.ctrl[0]};
        ADDR_CTRL1: next_st.rdata = {24'h000000, next_st.ctrl[1]};
        ADDR_CMP0: next_st.rdata = {24'h000000, next_st.cmp[0]};
        ADDR_CMP1: next_st.rdata = {24'h000000, next_st.cmp[1]};
        ADDR_SYS: next_st.rdata = {29'h00000000, next_st.pwr, next_st.slow_sel};
        ADDR_STAT: next_st.rdata = {14'h0000, st.ff, cnt1, cnt0};
        default: next_st.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st <= '0;
      st.ctrl <= {CTRL_RST, CTRL_RST};
      st.cmp <= {CMP_RST, CMP_RST};
      st.slow_sel <= SLOW_SEL_RST;
      st.pin_n <= 2'h3;
      st.ready <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign HRDATA = st.rdata;
  assign HREADYOUT = st.ready;
  assign HRESP = st.resp;
  assign DIV_OUT_N = st.pin_n;
  assign MATCH_IRQ = st.irq;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  sequence s_stop_write;
    st.wr_pend && st.wr_addr == ADDR_CTRL0 && run_bit[0] && !HWDATA[CTL_RUN_BIT];
  endsequence

  sequence s_div_match;
    match0 && mode[0] == MODE_DIVIDER;
  endsequence

  property p_timer_match;
    (match0 && mode[0] == MODE_TIMER) |=> (cnt0 == 8'h00 && MATCH_IRQ[0]) ##1 !MATCH_IRQ[0];
  endproperty
  a_timer_match: assert property (p_timer_match) else $error("timer match did not clear or interrupt");

  property p_event_count;
    (fall[0] && run0 && !cascade && mode[0] == MODE_TIMER && csel[0] == CSEL_PIN && !match0)
      |=> cnt0 == 8'($past(cnt0) + 8'h01);
  endproperty
  a_event_count: assert property (p_event_count) else $error("event edge not counted");

  property p_no_edge_hold;
    (run0 && !cascade && csel[0] == CSEL_PIN && !fall[0]) |=> $stable(cnt0);
  endproperty
  a_no_edge_hold: assert property (p_no_edge_hold) else $error("event count moved without edge");

  property p_compare_now;
    (st.wr_pend && st.wr_addr == ADDR_CMP0) |=> st.cmp[0] == $past(HWDATA[7:0]);
  endproperty
  a_compare_now: assert property (p_compare_now) else $error("compare write not immediate");

  property p_div_toggle;
    s_div_match |=> (st.ff[0] != $past(st.ff[0])) && (DIV_OUT_N[0] == $past(st.ff[0])) && cnt0 == 8'h00;
  endproperty
  a_div_toggle: assert property (p_div_toggle) else $error("divider did not toggle on match");

  property p_pin_inverse;
    DIV_OUT_N == ~st.ff;
  endproperty
  a_pin_inverse: assert property (p_pin_inverse) else $error("divider pin not inverse of flip-flop");

  property p_ff_load;
    (st.wr_pend && st.wr_addr == ADDR_CTRL0 && !run_bit[0]) |=> st.ff[0] == $past(HWDATA[CTL_FF_BIT]);
  endproperty
  a_ff_load: assert property (p_ff_load) else $error("flip-flop not loaded by control write");

  property p_stop_hold;
    s_stop_write |=> $stable(DIV_OUT_N[0]) ##1 (st.wr_pend || $stable(DIV_OUT_N[0]));
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("pin changed on stopping write");

  property p_cascade_clock;
    (cascade && run1 && !match_cas) |-> (adv1 == src_tick[0]) && (inc1 == carry0);
  endproperty
  a_cascade_clock: assert property (p_cascade_clock) else $error("cascade not clocked by lower stage");

  property p_low_power_src;
    (low_power && csel[0] != CSEL_SLOW && csel[0] != CSEL_PIN) |-> !src_tick[0];
  endproperty
  a_low_power_src: assert property (p_low_power_src) else $error("fast source ticked in low power");

  property p_slow_select;
    (!low_power && csel[0] == CSEL_SLOW) |-> src_tick[0] == (st.slow_sel ? tick_fs3 : tick_fc11);
  endproperty
  a_slow_select: assert property (p_slow_select) else $error("slow source select wrong");

  property p_stop_clear;
    !run0 |=> cnt0 == 8'h00;
  endproperty
  a_stop_clear: assert property (p_stop_clear) else $error("stopped counter not cleared");

  property p_timer_match1;
    (match1 && !cascade && mode[1] == MODE_TIMER) |=> cnt1 == 8'h00 && MATCH_IRQ[1];
  endproperty
  a_timer_match1: assert property (p_timer_match1) else $error("upper timer match did not clear");

  property p_cascade_match;
    match_cas |=> cnt0 == 8'h00 && cnt1 == 8'h00 && MATCH_IRQ[1];
  endproperty
  a_cascade_match: assert property (p_cascade_match) else $error("cascade match did not clear");

  property p_div_toggle1;
    (match1 && mode[1] == MODE_DIVIDER) |=> st.ff[1] != $past(st.ff[1]);
  endproperty
  a_div_toggle1: assert property (p_div_toggle1) else $error("upper divider did not toggle");

  property p_stop_clear1;
    !run1 |=> cnt1 == 8'h00;
  endproperty
  a_stop_clear1: assert property (p_stop_clear1) else $error("stopped upper counter not cleared");

  property p_mode_idle;
    (!cascade && !counts[0]) |=> cnt0 == 8'h00;
  endproperty
  a_mode_idle: assert property (p_mode_idle) else $error("non-counting mode moved the count");

  property p_fall_pattern;
    fall[0] |-> $past(EVENT_IN[0], 3) && !$past(EVENT_IN[0], 2);
  endproperty
  a_fall_pattern: assert property (p_fall_pattern) else $error("edge seen without high then low");

  property p_low_power_src1;
    (low_power && csel[1] != CSEL_SLOW && csel[1] != CSEL_PIN) |-> !src_tick[1];
  endproperty
  a_low_power_src1: assert property (p_low_power_src1) else $error("upper fast source ticked in low power");

  property p_cascade_hold;
    (cascade && run1 && !src_tick[0]) |=> $stable(cnt1);
  endproperty
  a_cascade_hold: assert property (p_cascade_hold) else $error("upper stage moved on its own clock");

endmodule // tmrdv_top

//--- tmrdv_evt_src.sv
/*
  Far-side model: an external event source that makes one falling edge on
  the requested event input pin per request, the line idling high.
  Assumes requests come from the bench one at a time, only while idle.
*/
`timescale 1ns/1ns
module tmrdv_evt_src #(
  parameter int HOLD = 4
) (
  input wire logic clk, // System clock
  input wire logic rst, // Async reset, high
  input wire logic [1:0] go, // One-cycle request per pin
  output logic [1:0] evt, // Event input pins
  output logic busy // Pulse in progress
);
  int cnt;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      evt <= 2'b11;
      busy <= 1'b0;
      cnt <= 0;
    end else if (!busy && go != 2'b00) begin
      evt <= ~go;
      busy <= 1'b1;
      cnt <= 1;
    end else if (busy) begin
      cnt <= cnt + 1;
      // Low and high each held HOLD cycles, above the two-cycle minimum
      if (cnt == HOLD) begin
        evt <= 2'b11;
      end
      if (cnt == 2 * HOLD) begin
        busy <= 1'b0;
      end
    end
  end
endmodule // tmrdv_evt_src

//--- tmrdv_top_tb.sv
/*
  Self-checking bench for tmrdv_top: AHB-Lite register tasks, cycle gaps
  between matches and pin toggles, event pulses from tmrdv_evt_src.
  Assumes FS_DIV of 4 so the slow source ticks every 32 cycles.
*/
`timescale 1ns/1ns
module tmrdv_top_tb;
  import tmrdv_pkg::*;
  logic clk, rst, hsel, hwrite, hready, hreadyout, hresp, busy;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans, go, evt, dout, irq;
  int err_total, checks, cyc, n0;
  int ic [2];
  int exp_gap [4] = '{4096, 256, 64, 16};

  assign hready = hreadyout;

  tmrdv_top #(.FS_DIV(4)) i_tmrdv_top (.CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .EVENT_IN(evt), .DIV_OUT_N(dout), .MATCH_IRQ(irq));

  tmrdv_evt_src i_tmrdv_evt_src (.clk(clk), .rst(rst), .go(go), .evt(evt), .busy(busy));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic complete_run;
    if (err_total == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (irq[0] === 1'b1) ic[0]++;
    if (irq[1] === 1'b1) ic[1]++;
    // Ceiling well above the roughly 21000 cycles the tests need
    if (cyc == 60000) begin
      err_total++;
      complete_run;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Entered just after a rising edge; holds each phase until hready
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h00000000);
    check(q, exp);
  endtask

  function automatic logic sig(input int s);
    return (s < 2) ? irq[s] : dout[s - 2];
  endfunction

  task automatic next_ev(input int s, output int n);
    logic p;
    p = sig(s);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!((s < 2) ? sig(s) === 1'b1 : sig(s) !== p) && n < 5000);
  endtask

  // Two successive intervals between matches or pin toggles
  task automatic gap(input int s, input int exp);
    int n;
    next_ev(s, n);
    repeat (2) begin
      next_ev(s, n);
      check(32'(n), 32'(exp));
    end
  endtask

  task automatic fall(input int b);
    go[b] <= 1'b1;
    @(posedge clk);
    go <= 2'b00;
    for (int i = 0; i < 20; i++) begin
      @(posedge clk);
      if (!busy) break;
    end
  endtask

  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h00000000;
    go = 2'b00;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check(32'(dout), 32'h00000003);
    check(32'(hresp), 32'h00000000);
    rc(ADDR_CMP0, 32'h000000FF);
    rc(ADDR_CMP1, 32'h000000FF);
    rc(ADDR_CTRL0, 32'h00000000);
    rc(ADDR_SYS, 32'h00000000);
    rc(ADDR_STAT, 32'h00000000);
    wr(8'h20, 32'h0000005A);
    rc(8'h20, 32'h00000000);
    // Full speed sources, flip-flop bit kept 0 in timer mode
    wr(ADDR_CMP0, 32'h00000002);
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_CTRL0, 32'h00000008 | (k << 4));
      gap(0, exp_gap[k]);
      wr(ADDR_CTRL0, 32'h00000000);
      rc(ADDR_STAT, 32'h00000000);
    end
    wr(ADDR_SYS, 32'h00000001);
    wr(ADDR_CTRL0, 32'h00000008);
    gap(0, 64);
    wr(ADDR_CTRL0, 32'h00000000);
    // Low clock power mode: fast sources must stay silent
    wr(ADDR_SYS, 32'h00000004);
    wr(ADDR_CTRL0, 32'h00000038);
    n0 = ic[0];
    repeat (60) @(posedge clk);
    check(32'(ic[0] - n0), 32'h00000000);
    rc(ADDR_STAT, 32'h00000000);
    wr(ADDR_CTRL0, 32'h00000000);
    wr(ADDR_CTRL0, 32'h00000008);
    gap(0, 64);
    wr(ADDR_CTRL0, 32'h00000000);
    wr(ADDR_SYS, 32'h00000000);
    // Compare write while running acts at once
    wr(ADDR_CTRL0, 32'h00000038);
    gap(0, 16);
    wr(ADDR_CMP0, 32'h00000005);
    gap(0, 40);
    wr(ADDR_CTRL0, 32'h00000000);
    // Divider: 50% square wave, then stop and flip-flop loads
    wr(ADDR_CMP0, 32'h00000004);
    wr(ADDR_CTRL0, 32'h00000039);
    gap(2, 32);
    n0 = dout[0];
    // Flip-flop bit in the stopping write must not move the pin
    wr(ADDR_CTRL0, 32'h00000081);
    repeat (40) @(posedge clk);
    check(32'(dout[0]), 32'(n0));
    rc(ADDR_STAT, 32'(!n0) << STAT_FF_LSB);
    wr(ADDR_CTRL0, 32'h00000081);
    repeat (2) @(posedge clk);
    check(32'(dout[0]), 32'h00000000);
    wr(ADDR_CTRL0, 32'h00000001);
    repeat (2) @(posedge clk);
    check(32'(dout[0]), 32'h00000001);
    wr(ADDR_CTRL0, 32'h00000081);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    check(32'(dout), 32'h00000003);
    rst <= 1'b0;
    @(posedge clk);
    rc(ADDR_STAT, 32'h00000000);
    // Event counting on each pin, compare 3
    for (int b = 0; b < 2; b++) begin
      wr(8'(ADDR_CMP0 + 4 * b), 32'h00000003);
      wr(8'(ADDR_CTRL0 + 4 * b), 32'h00000078);
      n0 = ic[b];
      fall(b);
      fall(b);
      rc(ADDR_STAT, 32'h00000002 << (8 * b));
      check(32'(ic[b] - n0), 32'h00000000);
      fall(b);
      check(32'(ic[b] - n0), 32'h00000001);
      rc(ADDR_STAT, 32'h00000000);
      wr(8'(ADDR_CTRL0 + 4 * b), 32'h00000000);
    end
    // Cascade: lower clock select rules, upper select set to pin
    wr(ADDR_CMP0, 32'h00000002);
    wr(ADDR_CMP1, 32'h00000000);
    wr(ADDR_CTRL0, 32'h00000030);
    wr(ADDR_CTRL1, 32'h0000007C);
    gap(1, 16);
    wr(ADDR_CTRL1, 32'h00000000);
    wr(ADDR_CMP0, 32'h00000001);
    wr(ADDR_CMP1, 32'h00000001);
    wr(ADDR_CTRL1, 32'h0000007C);
    gap(1, 2056);
    wr(ADDR_CTRL1, 32'h00000000);
    // Upper divider, then modes that keep the count at zero
    wr(ADDR_CMP1, 32'h00000004);
    wr(ADDR_CTRL1, 32'h00000039);
    gap(3, 32);
    wr(ADDR_CTRL1, 32'h00000000);
    wr(ADDR_CMP0, 32'h00000000);
    wr(ADDR_CMP1, 32'h00000001);
    for (int m = 2; m < 8; m++) begin
      if (m != 4) begin
        wr(ADDR_CTRL1, 32'h00000038 | m);
        repeat (20) @(posedge clk);
        rc(ADDR_STAT, 32'h00000000);
      end
    end
    check(32'(dout), 32'h00000003);
    wr(ADDR_CTRL1, 32'h00000000);
    complete_run;
  end
endmodule // tmrdv_top_tb
